// ===== rtl/pmsc_pkg.sv
// package: register map, field positions, reset values and carriers for the panel status block
package pmsc_pkg;
   localparam logic [7:0] ADDR_MAP_VERSION = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h01;
   localparam logic [7:0] ADDR_ERROR_CODE = 8'h02;
   localparam logic [7:0] ADDR_HOURS_HIGH = 8'h03;
   localparam logic [7:0] ADDR_HOURS_LOW = 8'h04;
   localparam logic [7:0] ADDR_CONTROL = 8'h20;
   localparam logic [7:0] ADDR_CLEAR = 8'h27;
   localparam int BIT_ERROR_FLAG = 7;
   localparam int BIT_HOURS_UPD = 6;
   localparam int BIT_MAINS_LOSS = 5;
   localparam int BIT_PAT_SEL = 7;
   localparam int BIT_PAT_EN = 6;
   localparam int BIT_VIDEO_EN = 5;
   localparam int BIT_POLARITY = 3;
   localparam int BIT_PFC_FORCE = 2;
   localparam int BIT_HV_ON = 1;
   localparam int BIT_CLR_ERR = 6;
   localparam int BIT_CLR_HOURS = 5;
   localparam int BIT_CLR_MAINS = 4;
   localparam logic [7:0] CONTROL_RESET = 8'h28;
   localparam logic [7:0] CONTROL_WMASK = 8'hEE;
   localparam logic [7:0] ERROR_CODE_RESET = 8'h00;
   localparam logic [15:0] HOURS_RESET = 16'h0000;
   localparam int CLK_HZ = 50000000;
   localparam int COLOUR_PERIOD_S = 2;
   localparam int COLOUR_CYCLES = CLK_HZ * COLOUR_PERIOD_S;
   localparam int COLOUR_COUNT = 8;
   localparam int HISTORY_DEPTH = 16;
   localparam int SYNC_STAGES = 3;

   typedef struct packed {
      logic pattern_select;
      logic pattern_enable;
      logic video_enable;
      logic emission_polarity;
      logic pfc_force_on;
      logic high_voltage_on;
   } pmsc_ctrl_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } pmsc_req_t;
endpackage : pmsc_pkg

// ===== rtl/pmsc_regs.sv
// panel module status and control register set behind the two-wire target's byte port
`timescale 1ns/1ps
// Summary of operation
// - read-only map version byte at sub-address 00.
// - error flag bit 7 of 01 sets on error, clears only by clear control.
// - with error flag set, code recorded and panel-on mode refused.
// - status bit 6 is hours-updated flag, resets to 0.
// - bit 5 sets after mains loss shutdown, held until its clear control.
// - bits 4-0 of status report the module condition code.
// - error code at 02 resets to 00; sixteen past codes selectable.
// - a repeat of the latest error code adds no history entry.
// - 16-bit hours count, high byte at 03, low byte at 04, reset 00.
// - pattern select 0 shows single colours, changing every 2 s, 8 colours.
// - register 20 bit 6 selects test pattern; select bit used only then.
// - bit 5 zero blanks the screen, one shows video; resets to 1.
// - bit 3 sets emission polarity, resets to 1.
// - pfc start rises before high voltage; force bit holds it high.
// - bit 1 of register 20 switches high voltage, resets to 0.
// - host reaches all registers over the two-wire bus as target.
// - writing the error clear clears the flag; control self-returns to 0.
// - interrupt output rises on supply decrease or circuit abnormality.
module pmsc_regs #(
   parameter logic [7:0] MAP_VERSION = 8'h5A, // arbitrary value
   parameter int COLOUR_CYC = pmsc_pkg::COLOUR_CYCLES,
   parameter int DEPTH = pmsc_pkg::HISTORY_DEPTH
) (
   input wire logic clk, // 50 MHz clock
   input wire logic rst, // async reset, high
   input wire pmsc_pkg::pmsc_req_t req, // byte access from two-wire target
   input wire logic [3:0] history_select, // 0 latest, 15 oldest error
   input wire logic error_event, // pulse: new error with code
   input wire logic [7:0] error_code_in, // code of new error
   input wire logic hours_tick, // pulse: one more driving hour
   input wire logic [4:0] condition_code, // module condition from processor
   input wire logic mains_loss_pin, // mains loss detected, async
   input wire logic supply_fault_pin, // supply decrease or abnormality, async
   input wire logic hv_ready_pin, // high voltage output ready, async
   output logic [7:0] rdata, // read data, valid cycle after rd
   output logic rvalid, // read data strobe
   output pmsc_pkg::pmsc_ctrl_t ctrl, // control settings
   output logic panel_on_mode, // panel-on mode active
   output logic pfc_start_out, // power factor correction start
   output logic hv_enable_out, // high voltage supply enable
   output logic [2:0] colour_index, // test pattern colour
   output logic irq_out // interrupt request
);
   typedef struct packed {
      logic [7:0] control;
      logic error_flag;
      logic hours_updated_flag;
      logic mains_loss_flag;
      logic [7:0] error_code;
      logic [15:0] hours;
      logic [$clog2(DEPTH)-1:0] wr_ptr;
      logic [$clog2(DEPTH):0] fill;
      logic [31:0] colour_cnt;
      logic [2:0] colour;
      logic [2:0] mains_sync;
      logic [2:0] fault_sync;
      logic [2:0] hv_sync;
      logic mains_lvl;
      logic fault_lvl;
      logic hv_lvl;
      logic pfc;
      logic hv_en;
      logic on_mode;
      logic irq;
      logic [7:0] rdata;
      logic rvalid;
   } pmsc_state_t;

   pmsc_state_t s_q;
   pmsc_state_t s_d;
   logic [7:0] hist_q [DEPTH];
   logic hist_push;

   function automatic logic settle(input logic [2:0] sy, input logic lvl);
      settle = (sy[1] == sy[2]) ? sy[2] : lvl;
   endfunction : settle

   logic [7:0] status_byte;
   logic [7:0] hist_byte;
   logic [$clog2(DEPTH)-1:0] hist_idx;

   always_comb begin
      status_byte = {s_q.error_flag, s_q.hours_updated_flag, s_q.mains_loss_flag,
                     condition_code};
      hist_idx = s_q.wr_ptr - 1'b1 - history_select[$clog2(DEPTH)-1:0];
      hist_byte = (history_select < s_q.fill) ? hist_q[hist_idx] : 8'h00;
   end

   always_comb begin
      s_d = s_q;
      hist_push = 1'b0;
      s_d.mains_sync = {s_q.mains_sync[1:0], mains_loss_pin};
      s_d.fault_sync = {s_q.fault_sync[1:0], supply_fault_pin};
      s_d.hv_sync = {s_q.hv_sync[1:0], hv_ready_pin};
      s_d.mains_lvl = settle(s_q.mains_sync, s_q.mains_lvl);
      s_d.fault_lvl = settle(s_q.fault_sync, s_q.fault_lvl);
      s_d.hv_lvl = settle(s_q.hv_sync, s_q.hv_lvl);
      s_d.rvalid = 1'b0;
      if (req.wr) begin
         if (req.addr == pmsc_pkg::ADDR_CONTROL) begin
            s_d.control = req.wdata & pmsc_pkg::CONTROL_WMASK;
         end
         if (req.addr == pmsc_pkg::ADDR_CLEAR && req.wdata[pmsc_pkg::BIT_CLR_ERR]) begin
            s_d.error_flag = 1'b0;
         end
         if (req.addr == pmsc_pkg::ADDR_CLEAR && req.wdata[pmsc_pkg::BIT_CLR_HOURS]) begin
            s_d.hours_updated_flag = 1'b0;
         end
         if (req.addr == pmsc_pkg::ADDR_CLEAR && req.wdata[pmsc_pkg::BIT_CLR_MAINS]) begin
            s_d.mains_loss_flag = 1'b0;
         end
      end
      // error sets flag, set beats clear
      if (error_event) begin
         s_d.error_flag = 1'b1;
         s_d.error_code = error_code_in;
         if (s_q.fill == '0 || hist_q[s_q.wr_ptr - 1'b1] != error_code_in) begin
            hist_push = 1'b1;
            s_d.wr_ptr = s_q.wr_ptr + 1'b1;
            if (s_q.fill != DEPTH[$clog2(DEPTH):0]) begin
               s_d.fill = s_q.fill + 1'b1;
            end
         end
      end
      if (hours_tick) begin
         s_d.hours = s_q.hours + 16'h0001;
         s_d.hours_updated_flag = 1'b1;
      end
      if (s_q.mains_lvl) begin
         s_d.hv_en = 1'b0;
         s_d.on_mode = 1'b0;
         if (!s_q.hv_en) begin
            s_d.mains_loss_flag = 1'b1;
         end
      end else begin
         s_d.hv_en = s_q.control[pmsc_pkg::BIT_HV_ON] && !s_q.error_flag && s_q.pfc;
         s_d.on_mode = s_q.hv_en && s_q.hv_lvl && !s_q.error_flag;
      end
      // pfc ahead of high voltage or forced
      s_d.pfc = s_q.control[pmsc_pkg::BIT_PFC_FORCE] ||
                (s_q.control[pmsc_pkg::BIT_HV_ON] && !s_q.mains_lvl);
      if (s_q.fault_lvl || s_q.mains_lvl) begin
         s_d.irq = 1'b1;
      end else if (req.wr && req.addr == pmsc_pkg::ADDR_CLEAR && req.wdata[7]) begin
         s_d.irq = 1'b0;
      end
      // colour every 2 s through 8
      // select valid only with pattern on
      if (s_q.control[pmsc_pkg::BIT_PAT_EN] && !s_q.control[pmsc_pkg::BIT_PAT_SEL]) begin
         if (s_q.colour_cnt >= 32'(COLOUR_CYC - 1)) begin
            s_d.colour_cnt = '0;
            s_d.colour = 3'((int'(s_q.colour) + 1) % pmsc_pkg::COLOUR_COUNT);
         end else begin
            s_d.colour_cnt = s_q.colour_cnt + 32'd1;
         end
      end else begin
         s_d.colour_cnt = '0;
         s_d.colour = '0;
      end
      if (req.rd) begin
         s_d.rvalid = 1'b1;
         case (req.addr)
            pmsc_pkg::ADDR_MAP_VERSION: s_d.rdata = MAP_VERSION;
            pmsc_pkg::ADDR_STATUS: s_d.rdata = status_byte;
            pmsc_pkg::ADDR_ERROR_CODE: begin
               s_d.rdata = (history_select == 4'h0) ? s_q.error_code : hist_byte;
            end
            pmsc_pkg::ADDR_HOURS_HIGH: s_d.rdata = s_q.hours[15:8];
            pmsc_pkg::ADDR_HOURS_LOW: s_d.rdata = s_q.hours[7:0];
            pmsc_pkg::ADDR_CONTROL: s_d.rdata = s_q.control;
            default: s_d.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.control <= pmsc_pkg::CONTROL_RESET;
         s_q.error_code <= pmsc_pkg::ERROR_CODE_RESET;
         s_q.hours <= pmsc_pkg::HOURS_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   always_ff @(posedge clk) begin
      if (hist_push) begin
         hist_q[s_q.wr_ptr] <= error_code_in;
      end
   end

   always_comb begin
      rdata = s_q.rdata;
      rvalid = s_q.rvalid;
      ctrl.pattern_select = s_q.control[pmsc_pkg::BIT_PAT_SEL];
      ctrl.pattern_enable = s_q.control[pmsc_pkg::BIT_PAT_EN];
      ctrl.video_enable = s_q.control[pmsc_pkg::BIT_VIDEO_EN];
      ctrl.emission_polarity = s_q.control[pmsc_pkg::BIT_POLARITY];
      ctrl.pfc_force_on = s_q.control[pmsc_pkg::BIT_PFC_FORCE];
      ctrl.high_voltage_on = s_q.control[pmsc_pkg::BIT_HV_ON];
      panel_on_mode = s_q.on_mode;
      pfc_start_out = s_q.pfc;
      hv_enable_out = s_q.hv_en;
      colour_index = s_q.colour;
      irq_out = s_q.irq;
   end
endmodule : pmsc_regs

// ===== tb/pmsc_checker.sv
// checker: timing relations at the status block's ports
`timescale 1ns/1ps
module pmsc_checker #(
   parameter logic [7:0] MAP_VERSION = 8'h5A // arbitrary value
) (
   input wire logic clk, // clock
   input wire logic rst, // reset
   input wire pmsc_pkg::pmsc_req_t req, // byte request
   input wire logic error_event, // new error
   input wire logic supply_fault_pin, // fault level
   input wire logic [7:0] rdata, // read data
   input wire logic rvalid, // read strobe
   input wire pmsc_pkg::pmsc_ctrl_t ctrl, // control bits
   input wire logic panel_on_mode, // panel-on
   input wire logic pfc_start_out, // pfc start
   input wire logic hv_enable_out, // hv enable
   input wire logic irq_out // interrupt
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_map_read: assert property (req.rd && req.addr == 8'h00 |=> rdata == MAP_VERSION)
      else $error("map version read wrong");
   a_rvalid_pulse: assert property (rvalid == $past(req.rd))
      else $error("read strobe misplaced");
   a_ctrl_write: assert property (req.wr && req.addr == 8'h20 |=>
      ctrl.video_enable == $past(req.wdata[5]) && ctrl.emission_polarity == $past(req.wdata[3])
      && ctrl.high_voltage_on == $past(req.wdata[1])) else $error("control write lost");
   a_hv_order: assert property ($rose(hv_enable_out) |-> $past(pfc_start_out))
      else $error("hv before pfc start");
   a_pfc_force: assert property (ctrl.pfc_force_on [*2] |-> pfc_start_out)
      else $error("pfc not forced");
   a_hv_off: assert property (!ctrl.high_voltage_on [*3] |-> !hv_enable_out)
      else $error("hv on while off");
   a_irq_fault: assert property (supply_fault_pin [*6] |-> irq_out)
      else $error("irq not raised");
   a_err_refuse: assert property (error_event |-> ##[1:3] !panel_on_mode)
      else $error("panel-on kept after error");
endmodule : pmsc_checker

bind pmsc_regs pmsc_checker #(.MAP_VERSION(MAP_VERSION)) u_chk (.clk(clk), .rst(rst),
   .req(req), .error_event(error_event), .supply_fault_pin(supply_fault_pin), .rdata(rdata),
   .rvalid(rvalid), .ctrl(ctrl), .panel_on_mode(panel_on_mode), .pfc_start_out(pfc_start_out),
   .hv_enable_out(hv_enable_out), .irq_out(irq_out));

// ===== tb/pmsc_host.sv
// host model: byte requests toward the status block
`timescale 1ns/1ps
module pmsc_host (
   input wire logic clk, // clock
   input wire logic [7:0] rdata, // read data
   input wire logic rvalid, // read strobe
   output pmsc_pkg::pmsc_req_t req // request
);
   initial req = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 req = '{addr: a, wdata: (a == 8'h20) ? (d & 8'hEF) : d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      #1 req = '{addr: ~a, wdata: ~req.wdata, wr: 1'b0, rd: 1'b0};
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge clk);
      #1 req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      #1 req = '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
      v = rvalid;
      d = rdata;
   endtask : rd
endmodule : pmsc_host

// ===== tb/testbench.sv
// testbench: registers, flags, history, power sequence, test pattern
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   pmsc_pkg::pmsc_req_t req;
   logic [3:0] history_select = 4'h0;
   logic error_event = 1'b0;
   logic [7:0] error_code_in = 8'h00;
   logic hours_tick = 1'b0;
   logic [4:0] condition_code = 5'h13;
   logic mains_loss_pin = 1'b0;
   logic supply_fault_pin = 1'b0;
   logic hv_ready_pin = 1'b0;
   logic [7:0] rdata;
   logic rvalid, panel_on_mode, pfc_start_out, hv_enable_out, irq_out;
   pmsc_pkg::pmsc_ctrl_t ctrl;
   logic [2:0] colour_index;
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;
   always #10 clk = ~clk;
   pmsc_host host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req));
   pmsc_regs #(.MAP_VERSION(8'h3C), .COLOUR_CYC(10)) DUT (.clk(clk), .rst(rst), .req(req),
      .history_select(history_select), .error_event(error_event),
      .error_code_in(error_code_in), .hours_tick(hours_tick), .condition_code(condition_code),
      .mains_loss_pin(mains_loss_pin), .supply_fault_pin(supply_fault_pin),
      .hv_ready_pin(hv_ready_pin), .rdata(rdata), .rvalid(rvalid), .ctrl(ctrl),
      .panel_on_mode(panel_on_mode), .pfc_start_out(pfc_start_out),
      .hv_enable_out(hv_enable_out), .colour_index(colour_index), .irq_out(irq_out));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      num_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic v;
      host.rd(a, d, v);
      chk("rvalid", 8'h01, {7'h00, v});
      chk($sformatf("reg %h", a), e, d);
   endtask : rdc
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_n
   task automatic pulse(input bit err, input logic [7:0] code);
      @(posedge clk);
      #1 error_code_in = code;
      error_event = err;
      hours_tick = !err;
      @(posedge clk);
      #1 error_event = 1'b0;
      hours_tick = 1'b0;
   endtask : pulse
   task automatic t_reset;
      host.wr(8'h00, 8'hFF);
      rdc(8'h00, 8'h3C);
      rdc(8'h01, 8'h13);
      rdc(8'h02, 8'h00);
      rdc(8'h03, 8'h00);
      rdc(8'h04, 8'h00);
      rdc(8'h20, 8'h28);
      rdc(8'h55, 8'h00);
      $display("test reset done");
   endtask : t_reset
   task automatic t_ctrl;
      hv_ready_pin = 1'b1;
      host.wr(8'h20, 8'h2A);
      wait_n(6);
      chk("hv", 8'h01, {7'h00, hv_enable_out});
      chk("pfc", 8'h01, {7'h00, pfc_start_out});
      chk("panel", 8'h01, {7'h00, panel_on_mode});
      host.wr(8'h20, 8'hFF);
      rdc(8'h20, 8'hEE);
      chk("ctrl", 8'h3F, {2'b00, ctrl});
      $display("test control done");
   endtask : t_ctrl
   task automatic t_error;
      pulse(1'b1, 8'h41);
      pulse(1'b1, 8'h41);
      pulse(1'b1, 8'h42);
      wait_n(3);
      chk("panel", 8'h00, {7'h00, panel_on_mode});
      rdc(8'h01, 8'h93);
      rdc(8'h02, 8'h42);
      history_select = 4'h1;
      rdc(8'h02, 8'h41);
      history_select = 4'h2;
      rdc(8'h02, 8'h00);
      history_select = 4'h0;
      host.wr(8'h27, 8'h40);
      rdc(8'h01, 8'h13);
      wait_n(6);
      chk("panel", 8'h01, {7'h00, panel_on_mode});
      $display("test error done");
   endtask : t_error
   task automatic t_hours;
      repeat (3) pulse(1'b0, 8'h00);
      rdc(8'h03, 8'h00);
      rdc(8'h04, 8'h03);
      rdc(8'h01, 8'h53);
      host.wr(8'h27, 8'h20);
      rdc(8'h01, 8'h13);
      $display("test hours done");
   endtask : t_hours
   task automatic t_mains;
      host.wr(8'h20, 8'h08);
      wait_n(4);
      chk("hv", 8'h00, {7'h00, hv_enable_out});
      chk("blank", 8'h00, {7'h00, ctrl.video_enable});
      mains_loss_pin = 1'b1;
      supply_fault_pin = 1'b1;
      wait_n(8);
      chk("irq", 8'h01, {7'h00, irq_out});
      mains_loss_pin = 1'b0;
      supply_fault_pin = 1'b0;
      wait_n(8);
      rdc(8'h01, 8'h33);
      host.wr(8'h27, 8'h90);
      rdc(8'h01, 8'h13);
      chk("irq", 8'h00, {7'h00, irq_out});
      $display("test mains done");
   endtask : t_mains
   task automatic t_pattern;
      logic [7:0] n;
      logic [2:0] c0;
      logic [2:0] p;
      host.wr(8'h20, 8'h68);
      c0 = colour_index;
      p = c0;
      n = 8'h00;
      repeat (80) begin
         @(posedge clk);
         #1 n = n + ((colour_index !== p) ? 8'h01 : 8'h00);
         p = colour_index;
      end
      chk("changes", 8'h08, n);
      chk("colour", {5'h00, c0}, {5'h00, colour_index});
      $display("test pattern done");
   endtask : t_pattern
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         end_sim();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      #1 rst = 1'b0;
      t_reset();
      t_ctrl();
      t_error();
      t_hours();
      t_mains();
      t_pattern();
      end_sim();
   end
endmodule : testbench
